/* File: bench/ccc_core_tb_top.sv */
// Self-checking bench for the call, clear, complement and compare execute slice.
`timescale 1ns/1ps
module ccc_core_tb_top;
  import ccc_pkg::*;
  // ----------------------------------------------------------------
  // Clock, reset and bus
  // ----------------------------------------------------------------
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire         busy;
  int          err_total = 0;
  int          n_tests   = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  ccc_core u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(HSIZE_WORD), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .busy_o(busy));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One idle cycle before each transfer keeps reads clear of a prior write.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys_i);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(nm, e, q);
  endtask : rdc

  function automatic logic [31:0] ra(input logic [7:0] n);
    return {22'h0, n, 2'h0};
  endfunction : ra

  task automatic launch(input logic [31:0] instr, input logic [31:0] n);
    int c;
    c = 0;
    wr({20'h0, ADDR_INSTR}, instr);
    #1;
    while (busy === 1'b1 && c < 40)
    begin
      @(posedge clk_sys_i);
      #1;
      c++;
    end
    chk("busy_cycles", n, c);
  endtask : launch

  task automatic cpt(input logic [31:0] instr, input logic [31:0] n, input logic [7:0] f);
    wr({20'h0, ADDR_FLAGS}, 32'h0C);
    launch(instr, n);
    rdc("cp_flags", {20'h0, ADDR_FLAGS}, {24'h0, f | 8'h0C});
  endtask : cpt

  task automatic endt(input string nm);
    $display("test %s done", nm);
  endtask : endt

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rdc("flags", {20'h0, ADDR_FLAGS}, {24'h0, FLAGS_RST});
    rdc("pc", {20'h0, ADDR_PC}, {16'h0, PC_RST});
    rdc("unmapped", 32'hC00, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    endt("reset");
    wr({20'h0, ADDR_FLAGS}, 32'h7C);
    launch({24'h0, OPC_CCF}, {27'h0, CYC_SHORT});
    rdc("flags", {20'h0, ADDR_FLAGS}, 32'hFC);
    launch({24'h0, OPC_CCF}, {27'h0, CYC_SHORT});
    rdc("flags", {20'h0, ADDR_FLAGS}, 32'h7C);
    endt("carry_invert");
    wr({20'h0, ADDR_FLAGS}, 32'hFC);
    wr({20'h0, ADDR_RP}, 32'h10);
    wr(ra(8'h16), 32'hAF);
    launch({16'h00E6, OPC_CLR_R}, {27'h0, CYC_SHORT});
    rdc("clr_reg", ra(8'h16), 32'h0);
    wr(ra(8'hA5), 32'h23);
    wr(ra(8'h23), 32'hFC);
    launch({16'h00A5, OPC_CLR_IR}, {27'h0, CYC_SHORT});
    rdc("clr_ind", ra(8'h23), 32'h0);
    rdc("flags", {20'h0, ADDR_FLAGS}, 32'hFC);
    endt("clear");
    wr(ra(8'h08), 32'h24);
    launch({16'h0008, OPC_COM_R}, {27'h0, CYC_SHORT});
    rdc("com_reg", ra(8'h08), 32'hDB);
    rdc("flags", {20'h0, ADDR_FLAGS}, 32'hAC);
    wr(ra(8'h08), 32'h24);
    wr(ra(8'h24), 32'hFF);
    launch({16'h0008, OPC_COM_IR}, {27'h0, CYC_SHORT});
    rdc("com_ind", ra(8'h24), 32'h0);
    rdc("flags", {20'h0, ADDR_FLAGS}, 32'hCC);
    endt("complement");
    wr(ra(8'h13), 32'h16);
    wr(ra(8'h1B), 32'h20);
    wr(ra(8'h1A), 32'h40);
    wr(ra(8'h40), 32'h16);
    wr(ra(8'h12), 32'h01);
    wr(ra(8'h34), 32'h80);
    wr(ra(8'h4B), 32'h82);
    wr(ra(8'h6C), 32'h2A);
    wr(ra(8'hD4), 32'hFC);
    wr(ra(8'hFC), 32'h8F);
    cpt({16'h003B, OPC_CP_RR}, {27'h0, CYC_SHORT}, 8'hA0);
    cpt({16'h003A, OPC_CP_RIR}, {27'h0, CYC_SHORT}, 8'h40);
    cpt({16'h3412, OPC_CP_R_R}, {27'h0, CYC_LONG}, 8'h10);
    cpt({16'h4BE3, OPC_CP_R_IR}, {27'h0, CYC_LONG}, 8'h20);
    cpt({16'h2A6C, OPC_CP_R_IM}, {27'h0, CYC_LONG}, 8'h40);
    cpt({16'hFFD4, OPC_CP_IR_IM}, {27'h0, CYC_LONG}, 8'hA0);
    rdc("cp_dst", ra(8'h34), 32'h80);
    rdc("cp_src", ra(8'h12), 32'h01);
    endt("compare");
    wr({20'h0, ADDR_FLAGS}, 32'h5C);
    wr({20'h0, ADDR_MODE}, 32'h0);
    wr(ra(8'hFF), 32'h72);
    wr({20'h0, ADDR_PC}, 32'h1A47);
    wr({20'h0, ADDR_RP}, 32'h30);
    wr(ra(8'h34), 32'h35);
    wr(ra(8'h35), 32'h21);
    launch({16'h00E4, OPC_CALL_IRR}, {27'h0, CYC_CALL});
    rdc("pc", {20'h0, ADDR_PC}, 32'h3521);
    rdc("sp_low", ra(8'hFF), 32'h70);
    rdc("push_hi", ra(8'h70), 32'h1A);
    rdc("push_lo", ra(8'h71), 32'h49);
    rdc("flags", {20'h0, ADDR_FLAGS}, 32'h5C);
    launch({24'h0, OPC_RET}, {27'h0, CYC_RET});
    rdc("pc", {20'h0, ADDR_PC}, 32'h1A49);
    rdc("sp_low", ra(8'hFF), 32'h72);
    endt("call_narrow");
    wr({20'h0, ADDR_MODE}, 32'h1);
    wr(ra(8'hFE), 32'h30);
    wr(ra(8'hFF), 32'h02);
    wr({20'h0, ADDR_PC}, 32'h1A47);
    launch({16'h2135, OPC_CALL_DA}, {27'h0, CYC_CALL});
    rdc("pc", {20'h0, ADDR_PC}, 32'h3521);
    rdc("sp_high", ra(8'hFE), 32'h30);
    rdc("sp_low", ra(8'hFF), 32'h00);
    rdc("ext_hi", 32'h800, 32'h1A);
    rdc("ext_lo", 32'h804, 32'h4A);
    endt("call_wide");
    launch({24'h0, 8'h00}, 32'h0);
    rdc("status", {20'h0, ADDR_STATUS}, 32'h00005C02);
    endt("illegal");
    conclude();
  end

  // A full run needs well under two thousand cycles.
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    conclude();
  end
endmodule : ccc_core_tb_top

/* File: rtl/ccc_alu.sv */
// Data and flag unit for clear, complement, compare and carry invert.
`timescale 1ns/1ps
module ccc_alu
(
  ccc_alu_if.alu alu
);
  import ccc_pkg::*;

  logic [8:0] diff;
  logic [7:0] inv;

  assign diff = {1'b0, alu.dst} - {1'b0, alu.src};
  assign inv  = ~alu.dst;

  always_comb
  begin
    alu.result    = alu.dst;
    alu.flags_out = alu.flags_in;
    alu.result_we = 1'b0;
    unique case (alu.op)
      CCC_ALU_PASS: ;
      CCC_ALU_CLR:
      begin
        alu.result    = 8'h00; // RULE_06
        alu.result_we = 1'b1; // RULE_13
      end
      CCC_ALU_COM:
      begin
        alu.result            = inv; // RULE_07
        alu.result_we         = 1'b1;
        alu.flags_out[FLAG_Z] = (inv == 8'h00); // RULE_08
        alu.flags_out[FLAG_S] = inv[7]; // RULE_08
        alu.flags_out[FLAG_V] = 1'b0; // RULE_08
      end
      CCC_ALU_CP: // RULE_09
      begin
        // A borrow out of bit 7 sets bit 8 of the nine-bit difference.
        alu.flags_out[FLAG_C] = diff[8]; // RULE_10
        alu.flags_out[FLAG_Z] = (diff[7:0] == 8'h00); // RULE_11
        alu.flags_out[FLAG_S] = diff[7]; // RULE_11
        alu.flags_out[FLAG_V] = (alu.dst[7] != alu.src[7]) && (diff[7] != alu.dst[7]); // RULE_11
      end
      CCC_ALU_CCF:
        alu.flags_out[FLAG_C] = ~alu.flags_in[FLAG_C]; // RULE_05
    endcase
  end

endmodule : ccc_alu

/* File: rtl/ccc_alu_if.sv */
// Operand and flag bundle between the execute core and its flag unit.
`timescale 1ns/1ps
interface ccc_alu_if;
  import ccc_pkg::*;
  ccc_alu_op_type op;
  logic [7:0]     dst;
  logic [7:0]     src;
  logic [7:0]     flags_in;
  logic [7:0]     result;
  logic [7:0]     flags_out;
  logic           result_we;

  modport core (output op, dst, src, flags_in, input result, flags_out, result_we);
  modport alu  (input op, dst, src, flags_in, output result, flags_out, result_we);
endinterface : ccc_alu_if

/* File: rtl/ccc_core.sv */
// Execute slice for call, return, carry invert, clear, complement and compare.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - Call lowers stack by two, pushes, jumps
// RULE_02 - Return pops stack word into fetch pointer
// RULE_03 - Call pair operand E-nibble picks working pair
// RULE_04 - Stack bytes FEh/FFh; wide mode uses external
// RULE_05 - Carry invert flips carry only, six cycles
// RULE_06 - Clear writes zero, keeps Z S V D H
// RULE_07 - Complement writes bitwise inverse of destination
// RULE_08 - Complement sets Z S, clears V, keeps rest
// RULE_09 - Compare subtracts for flags only, no writes
// RULE_10 - Compare carry means borrow out of bit 7
// RULE_11 - Compare sets Z S V, keeps D H
// RULE_12 - Operand E-nibble selects a working register
// RULE_13 - Clear keeps carry; call keeps all flags
// RULE_14 - Both complement forms take six cycles
module ccc_core
#(
  parameter int EXT_AW = 8
)
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             busy_o
);
  import ccc_pkg::*;

  localparam int EXT_DEPTH = 1 << EXT_AW;

  if (EXT_AW < 1 || EXT_AW > 8)
  begin : g_bad_ext_aw
    $error("EXT_AW must lie between 1 and 8");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [7:0]    rf_q [256];
  logic [7:0]    ext_q [EXT_DEPTH];
  ccc_state_type state_q;
  logic [4:0]    cnt_q;
  logic [23:0]   instr_q;
  logic          illegal_q;
  logic [7:0]    flags_q;
  logic [15:0]   pc_q;
  logic [7:0]    rp_q;
  logic          wide_q;
  logic          wr_pend_q;
  logic [11:0]   wr_addr_q;
  logic          wr_ok_q;
  logic [31:0]   rd_word;
  logic          bus_wr;
  logic          launch;
  logic          commit;

  logic [7:0]  opc;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  dst_addr;
  logic [7:0]  dst_val;
  logic [7:0]  src_val;
  logic [7:0]  pair_src;
  logic [7:0]  pair_addr;
  logic [15:0] call_target;
  logic [15:0] ret_addr;
  logic [15:0] pop_addr;
  logic [15:0] sp_cur;
  logic [15:0] sp_dn;
  logic [15:0] sp_dn1;
  logic [15:0] sp_up;
  logic [15:0] sp_up1;
  logic        is_call;
  ccc_alu_op_type op_sel;

  ccc_alu_if alu_bus ();

  ccc_alu u_alu
  (
    .alu (alu_bus.alu)
  );

  assign opc    = instr_q[7:0];
  assign b1     = instr_q[15:8];
  assign b2     = instr_q[23:16];
  assign commit = (state_q == CCC_RUN) && (cnt_q == 5'h00);
  assign bus_wr = wr_pend_q && wr_ok_q && (state_q == CCC_IDLE);
  assign launch = bus_wr && (wr_addr_q == ADDR_INSTR);
  assign is_call = (opc == OPC_CALL_DA) || (opc == OPC_CALL_IRR);

  // ------------------------------------------------------------------
  // Operand decode
  // ------------------------------------------------------------------
  always_comb
  begin
    dst_addr = reg_addr(b1, rp_q); // RULE_12
    src_val  = 8'h00;
    op_sel   = CCC_ALU_PASS;
    unique case (opc)
      OPC_CCF:    op_sel = CCC_ALU_CCF;
      OPC_CLR_R:  op_sel = CCC_ALU_CLR;
      OPC_CLR_IR:
      begin
        op_sel   = CCC_ALU_CLR;
        dst_addr = rf_q[reg_addr(b1, rp_q)];
      end
      OPC_COM_R:  op_sel = CCC_ALU_COM;
      OPC_COM_IR:
      begin
        op_sel   = CCC_ALU_COM;
        dst_addr = rf_q[reg_addr(b1, rp_q)];
      end
      OPC_CP_RR:
      begin
        op_sel   = CCC_ALU_CP;
        dst_addr = {rp_q[7:4], b1[7:4]};
        src_val  = rf_q[{rp_q[7:4], b1[3:0]}];
      end
      OPC_CP_RIR:
      begin
        op_sel   = CCC_ALU_CP;
        dst_addr = {rp_q[7:4], b1[7:4]};
        src_val  = rf_q[rf_q[{rp_q[7:4], b1[3:0]}]];
      end
      OPC_CP_R_R:
      begin
        op_sel   = CCC_ALU_CP;
        dst_addr = reg_addr(b2, rp_q); // RULE_12
        src_val  = rf_q[reg_addr(b1, rp_q)];
      end
      OPC_CP_R_IR:
      begin
        op_sel   = CCC_ALU_CP;
        dst_addr = reg_addr(b2, rp_q);
        src_val  = rf_q[rf_q[reg_addr(b1, rp_q)]];
      end
      OPC_CP_R_IM:
      begin
        op_sel  = CCC_ALU_CP;
        src_val = b2;
      end
      OPC_CP_IR_IM:
      begin
        op_sel   = CCC_ALU_CP;
        dst_addr = rf_q[reg_addr(b1, rp_q)];
        src_val  = b2;
      end
      default: ;
    endcase
  end

  assign dst_val = rf_q[dst_addr];

  assign alu_bus.op       = op_sel;
  assign alu_bus.dst      = dst_val;
  assign alu_bus.src      = src_val;
  assign alu_bus.flags_in = flags_q;

  // ------------------------------------------------------------------
  // Stack and call targets
  // ------------------------------------------------------------------
  // In narrow mode the high pointer byte is ignored so that pushes stay on chip.
  assign sp_cur    = wide_q ? {rf_q[SP_HI_ADDR], rf_q[SP_LO_ADDR]} : {8'h00, rf_q[SP_LO_ADDR]}; // RULE_04
  assign sp_dn     = sp_cur - 16'h0002; // RULE_01
  assign sp_dn1    = sp_cur - 16'h0001;
  assign sp_up     = sp_cur + 16'h0002; // RULE_02
  assign sp_up1    = sp_cur + 16'h0001;
  assign pair_src  = reg_addr(b1, rp_q); // RULE_03
  assign pair_addr = {pair_src[7:1], 1'b0}; // RULE_03
  assign ret_addr  = pc_q + length_of(opc);
  assign call_target = (opc == OPC_CALL_DA) ? {b1, b2}
                                             : {rf_q[pair_addr], rf_q[pair_addr | 8'h01]};
  assign pop_addr  = wide_q ? {ext_q[sp_cur[EXT_AW-1:0]], ext_q[sp_up1[EXT_AW-1:0]]}
                            : {rf_q[sp_cur[7:0]], rf_q[sp_up1[7:0]]}; // RULE_02

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_q   <= CCC_IDLE;
      cnt_q     <= 5'h00;
      instr_q   <= 24'h000000;
      illegal_q <= 1'b0;
      busy_o    <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        CCC_IDLE:
          if (launch)
          begin
            instr_q   <= hwdata_i[23:0];
            // Unknown opcodes are refused here and only load instr_q and illegal_q.
            illegal_q <= (cycles_of(hwdata_i[7:0]) == 5'h00);
            if (cycles_of(hwdata_i[7:0]) != 5'h00)
            begin
              state_q <= CCC_RUN;
              cnt_q   <= cycles_of(hwdata_i[7:0]) - 5'h01; // RULE_14
              busy_o  <= 1'b1;
            end
          end
        CCC_RUN:
          if (commit)
          begin
            state_q <= CCC_IDLE;
            busy_o  <= 1'b0;
          end
          else
            cnt_q <= cnt_q - 5'h01;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Architectural registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      pc_q <= PC_RST;
    else if (commit)
    begin
      if (is_call)
        pc_q <= call_target; // RULE_01
      else if (opc == OPC_RET)
        pc_q <= pop_addr; // RULE_02
      else
        pc_q <= ret_addr;
    end
    else if (bus_wr && wr_addr_q == ADDR_PC)
      pc_q <= hwdata_i[15:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      flags_q <= FLAGS_RST;
    else if (commit)
      flags_q <= alu_bus.flags_out; // RULE_13
    else if (bus_wr && wr_addr_q == ADDR_FLAGS)
      flags_q <= hwdata_i[7:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rp_q   <= RP_RST;
      wide_q <= 1'b0;
    end
    else if (bus_wr)
    begin
      if (wr_addr_q == ADDR_RP)
        rp_q <= hwdata_i[7:0];
      if (wr_addr_q == ADDR_MODE)
        wide_q <= hwdata_i[0];
    end
  end

  // The pointer bytes are written after the push so an overlapping push loses.
  always_ff @(posedge clk_sys_i)
  begin
    if (commit)
    begin
      if (alu_bus.result_we)
        rf_q[dst_addr] <= alu_bus.result; // RULE_06
      if (is_call && !wide_q)
      begin
        rf_q[sp_dn[7:0]]  <= ret_addr[15:8]; // RULE_01
        rf_q[sp_dn1[7:0]] <= ret_addr[7:0];
      end
      if (is_call || opc == OPC_RET)
      begin
        rf_q[SP_LO_ADDR] <= is_call ? sp_dn[7:0] : sp_up[7:0]; // RULE_04
        if (wide_q)
          rf_q[SP_HI_ADDR] <= is_call ? sp_dn[15:8] : sp_up[15:8];
      end
    end
    else if (bus_wr && wr_addr_q[11:10] == REGION_RF)
      rf_q[wr_addr_q[9:2]] <= hwdata_i[7:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (commit && is_call && wide_q)
    begin
      ext_q[sp_dn[EXT_AW-1:0]]  <= ret_addr[15:8]; // RULE_04
      ext_q[sp_dn1[EXT_AW-1:0]] <= ret_addr[7:0];
    end
    else if (bus_wr && wr_addr_q[11:10] == REGION_EXT
             && {1'b0, wr_addr_q[9:2]} < 9'(EXT_DEPTH))
      ext_q[wr_addr_q[EXT_AW+1:2]] <= hwdata_i[7:0];
  end

  // ------------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------------
  always_comb
  begin
    rd_word = 32'h00000000;
    if (haddr_i[31:12] == 20'h00000)
    begin
      case (haddr_i[11:10])
        REGION_RF:  rd_word = {24'h000000, rf_q[haddr_i[9:2]]};
        REGION_CTL:
          case (haddr_i[11:0])
            ADDR_INSTR:  rd_word = {8'h00, instr_q};
            ADDR_STATUS: rd_word = {16'h0000, flags_q, 6'h00, illegal_q, busy_o};
            ADDR_FLAGS:  rd_word = {24'h000000, flags_q};
            ADDR_PC:     rd_word = {16'h0000, pc_q};
            ADDR_RP:     rd_word = {24'h000000, rp_q};
            ADDR_MODE:   rd_word = {31'h00000000, wide_q};
            default:     rd_word = 32'h00000000;
          endcase
        REGION_EXT:
          if ({1'b0, haddr_i[9:2]} < 9'(EXT_DEPTH))
            rd_word = {24'h000000, ext_q[haddr_i[EXT_AW+1:2]]};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // Zero wait states: read data is registered at the end of the address phase.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 12'h000;
      wr_ok_q     <= 1'b0;
      hrdata_o    <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      wr_pend_q <= 1'b0;
      if (hsel_i && hready_i && htrans_i[1])
      begin
        wr_pend_q <= hwrite_i;
        wr_addr_q <= haddr_i[11:0];
        wr_ok_q   <= (haddr_i[31:12] == 20'h00000) && (hsize_i == HSIZE_WORD);
        if (!hwrite_i)
          hrdata_o <= rd_word;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  logic [4:0] run_len_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || state_q == CCC_IDLE)
      run_len_q <= 5'h01;
    else
      run_len_q <= run_len_q + 5'h01;
  end

  property p_cycles;
    commit |-> run_len_q == cycles_of(opc);
  endproperty
  a_cycles: assert property (p_cycles) else $error("instruction length wrong"); // RULE_14

  property p_call_sp;
    commit && is_call |=> rf_q[SP_LO_ADDR] == 8'($past(sp_cur) - 16'h0002);
  endproperty
  a_call_sp: assert property (p_call_sp) else $error("call did not lower stack"); // RULE_01

  property p_call_pc;
    commit && is_call |=> pc_q == $past(call_target) && flags_q == $past(flags_q);
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("call target or flags wrong"); // RULE_13

  property p_call_push;
    commit && is_call && !wide_q |=> rf_q[$past(sp_dn[7:0])] == $past(ret_addr[15:8]);
  endproperty
  a_call_push: assert property (p_call_push) else $error("return address not pushed"); // RULE_04

  property p_ret_pc;
    commit && opc == OPC_RET |=> pc_q == $past(pop_addr);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return did not pop"); // RULE_02

  property p_ccf;
    commit && opc == OPC_CCF |=> flags_q == ($past(flags_q) ^ FLAG_C_MASK);
  endproperty
  a_ccf: assert property (p_ccf) else $error("carry invert wrong"); // RULE_05

  property p_clr;
    commit && op_sel == CCC_ALU_CLR |=> rf_q[$past(dst_addr)] == 8'h00 && flags_q == $past(flags_q);
  endproperty
  a_clr: assert property (p_clr) else $error("clear wrong"); // RULE_06

  property p_com;
    commit && op_sel == CCC_ALU_COM |=> rf_q[$past(dst_addr)] == ~$past(dst_val)
      && !flags_q[FLAG_V] && flags_q[FLAG_Z] == ($past(dst_val) == 8'hFF)
      && flags_q[FLAG_C] == $past(flags_q[FLAG_C]);
  endproperty
  a_com: assert property (p_com) else $error("complement wrong"); // RULE_08

  property p_cp;
    commit && op_sel == CCC_ALU_CP |-> !alu_bus.result_we ##1
      flags_q[FLAG_C] == ($past(dst_val) < $past(src_val))
      && flags_q[FLAG_Z] == ($past(dst_val) == $past(src_val))
      && flags_q[FLAG_H] == $past(flags_q[FLAG_H]);
  endproperty
  a_cp: assert property (p_cp) else $error("compare wrong"); // RULE_10

  property p_wreg;
    state_q == CCC_RUN && opc == OPC_CLR_R && b1[7:4] == WREG_NIBBLE
      |-> dst_addr == {rp_q[7:4], b1[3:0]};
  endproperty
  a_wreg: assert property (p_wreg) else $error("working register decode wrong"); // RULE_12

  property p_pair;
    opc == OPC_CALL_IRR && b1[7:4] == WREG_NIBBLE |-> pair_addr == {rp_q[7:4], b1[3:1], 1'b0};
  endproperty
  a_pair: assert property (p_pair) else $error("working pair decode wrong"); // RULE_03

  c_call_wide: cover property (commit && is_call && wide_q);
  c_ret:       cover property (commit && opc == OPC_RET);
  c_cp_borrow: cover property (commit && op_sel == CCC_ALU_CP && dst_val < src_val);
  c_illegal:   cover property (launch && cycles_of(hwdata_i[7:0]) == 5'h00);

endmodule : ccc_core

/* File: rtl/ccc_pkg.sv */
// Shared constants, types and decode functions for the call/clear/compare execute slice.
package ccc_pkg;

  // ------------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OPC_CALL_DA  = 8'hD6;
  localparam logic [7:0] OPC_CALL_IRR = 8'hD4;
  localparam logic [7:0] OPC_RET      = 8'h9F;
  localparam logic [7:0] OPC_CCF      = 8'hEF;
  localparam logic [7:0] OPC_CLR_R    = 8'hB0;
  localparam logic [7:0] OPC_CLR_IR   = 8'hB1;
  localparam logic [7:0] OPC_COM_R    = 8'h60;
  localparam logic [7:0] OPC_COM_IR   = 8'h61;
  localparam logic [7:0] OPC_CP_RR    = 8'hA2;
  localparam logic [7:0] OPC_CP_RIR   = 8'hA3;
  localparam logic [7:0] OPC_CP_R_R   = 8'hA4;
  localparam logic [7:0] OPC_CP_R_IR  = 8'hA5;
  localparam logic [7:0] OPC_CP_R_IM  = 8'hA6;
  localparam logic [7:0] OPC_CP_IR_IM = 8'hA7;

  // ------------------------------------------------------------------
  // Cycle counts and operand encoding
  // ------------------------------------------------------------------
  localparam logic [4:0] CYC_CALL  = 5'h14;
  localparam logic [4:0] CYC_RET   = 5'h0E;
  localparam logic [4:0] CYC_SHORT = 5'h06;
  localparam logic [4:0] CYC_LONG  = 5'h0A;
  localparam logic [3:0] WREG_NIBBLE = 4'hE;
  localparam logic [7:0] SP_HI_ADDR  = 8'hFE;
  localparam logic [7:0] SP_LO_ADDR  = 8'hFF;

  // ------------------------------------------------------------------
  // Flag byte layout
  // ------------------------------------------------------------------
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [7:0] FLAG_C_MASK = 8'h80;

  // ------------------------------------------------------------------
  // Bus map and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0]  REGION_RF   = 2'h0;
  localparam logic [1:0]  REGION_CTL  = 2'h1;
  localparam logic [1:0]  REGION_EXT  = 2'h2;
  localparam logic [11:0] ADDR_INSTR  = 12'h400;
  localparam logic [11:0] ADDR_STATUS = 12'h404;
  localparam logic [11:0] ADDR_FLAGS  = 12'h408;
  localparam logic [11:0] ADDR_PC     = 12'h40C;
  localparam logic [11:0] ADDR_RP     = 12'h410;
  localparam logic [11:0] ADDR_MODE   = 12'h414;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;
  localparam logic [7:0]  FLAGS_RST   = 8'h00;
  localparam logic [15:0] PC_RST      = 16'h0000;
  localparam logic [7:0]  RP_RST      = 8'h00;

  typedef enum logic [2:0] {
    CCC_ALU_PASS,
    CCC_ALU_CLR,
    CCC_ALU_COM,
    CCC_ALU_CP,
    CCC_ALU_CCF
  } ccc_alu_op_type;

  typedef enum logic {
    CCC_IDLE,
    CCC_RUN
  } ccc_state_type;

  // Zero marks an opcode that this slice does not execute.
  function automatic logic [4:0] cycles_of(input logic [7:0] opc);
    unique case (opc)
      OPC_CALL_DA, OPC_CALL_IRR: cycles_of = CYC_CALL;
      OPC_RET:                   cycles_of = CYC_RET;
      OPC_CCF, OPC_CLR_R, OPC_CLR_IR, OPC_COM_R, OPC_COM_IR,
      OPC_CP_RR, OPC_CP_RIR:     cycles_of = CYC_SHORT;
      OPC_CP_R_R, OPC_CP_R_IR, OPC_CP_R_IM, OPC_CP_IR_IM: cycles_of = CYC_LONG;
      default:                   cycles_of = 5'h00;
    endcase
  endfunction : cycles_of

  function automatic logic [15:0] length_of(input logic [7:0] opc);
    unique case (opc)
      OPC_CALL_DA, OPC_CP_R_R, OPC_CP_R_IR, OPC_CP_R_IM, OPC_CP_IR_IM: length_of = 16'h0003;
      OPC_RET, OPC_CCF:  length_of = 16'h0001;
      default:           length_of = 16'h0002;
    endcase
  endfunction : length_of

  function automatic logic [7:0] reg_addr(input logic [7:0] b, input logic [7:0] rp);
    reg_addr = (b[7:4] == WREG_NIBBLE) ? {rp[7:4], b[3:0]} : b;
  endfunction : reg_addr

endpackage : ccc_pkg
